// ===== rtl/rtcal_pkg.sv
// Constants and types of the alarm time/date match block
package rtcal_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_TIME = 8'h00;
  localparam logic [7:0] ADDR_DATE = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IMSK = 8'h10;

  // Implemented bits and field masks of the time and date words
  localparam logic [31:0] TIME_IMPL   = 32'h3f7f7f00;
  localparam logic [31:0] DATE_IMPL   = 32'h001f3f07;
  localparam logic [31:0] HOUR_MASK   = 32'h3f000000;
  localparam logic [31:0] MIN_T_MASK  = 32'h00700000;
  localparam logic [31:0] MIN_O_MASK  = 32'h000f0000;
  localparam logic [31:0] SEC_T_MASK  = 32'h00007000;
  localparam logic [31:0] SEC_O_MASK  = 32'h00000f00;
  localparam logic [31:0] MON_MASK    = 32'h001f0000;
  localparam logic [31:0] DAY_MASK    = 32'h00003f00;
  localparam logic [31:0] WDAY_MASK   = 32'h00000007;
  localparam logic [31:0] TIME_RESET  = 32'h00000000;
  localparam logic [31:0] DATE_RESET  = 32'h00000000;
  localparam logic [31:0] ZERO_WORD   = 32'h00000000;

  // Alarm control word layout
  localparam int CTRL_ARM_BIT  = 15;
  localparam int CTRL_WRAP_BIT = 14;
  localparam int CTRL_PIV_BIT  = 13;
  localparam int CTRL_MM_LSB   = 8;
  localparam int CTRL_MM_W     = 4;
  localparam int CTRL_CNT_LSB  = 0;
  localparam int CTRL_CNT_W    = 8;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_MAX  = 8'hff;
  localparam logic [7:0] COUNT_ONE  = 8'h01;

  // Interrupt status and mask layout
  localparam int IRQ_W        = 2;
  localparam int IRQ_EVENT    = 0;
  localparam int IRQ_DONE     = 1;
  localparam logic [IRQ_W-1:0] IRQ_NONE = 2'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MM_HALF  = 4'h0,
    MM_SEC   = 4'h1,
    MM_SECOND_TENS_DIGIT = 4'h2,
    MM_MIN   = 4'h3,
    MM_MINUTE_TENS_DIGIT = 4'h4,
    MM_HOUR  = 4'h5,
    MM_DAY   = 4'h6,
    MM_WEEK  = 4'h7,
    MM_MONTH = 4'h8,
    MM_YEAR  = 4'h9
  } rtcal_mode_e;

endpackage : rtcal_pkg

// ===== rtl/rtcal_match.sv
// Field comparator of the alarm against the running clock and calendar
`timescale 1ns/1ps
module rtcal_match
  import rtcal_pkg::*;
(
  // Running clock
  input  wire logic        half_tick,
  input  wire logic        half_phase,
  input  wire logic [31:0] now_time,
  input  wire logic [31:0] now_date,
  // Alarm setting
  input  wire logic [3:0]  match_mask,
  input  wire logic [31:0] alarm_time,
  input  wire logic [31:0] alarm_date,
  // Result
  output logic             hit
);

  logic [31:0] need_t;
  logic [31:0] need_d;
  logic        legal;
  logic        whole_sec;

  always_comb begin
    need_t    = ZERO_WORD;
    need_d    = ZERO_WORD;
    legal     = 1'b1;
    whole_sec = 1'b1;
    // From ten seconds up, each longer period adds the next field to compare, except that month compares the day in place of the weekday
    case (rtcal_mode_e'(match_mask))
      MM_HALF:  whole_sec = 1'b0;
      MM_SEC:   need_t = ZERO_WORD;
      MM_SECOND_TENS_DIGIT: need_t = SEC_O_MASK;
      MM_MIN:   need_t = SEC_O_MASK | SEC_T_MASK;
      MM_MINUTE_TENS_DIGIT: need_t = SEC_O_MASK | SEC_T_MASK | MIN_O_MASK;
      MM_HOUR:  need_t = TIME_IMPL & ~HOUR_MASK;
      MM_DAY:   need_t = TIME_IMPL;
      MM_WEEK: begin
        need_t = TIME_IMPL;
        need_d = WDAY_MASK;
      end
      MM_MONTH: begin
        need_t = TIME_IMPL;
        need_d = DAY_MASK;
      end
      MM_YEAR: begin
        need_t = TIME_IMPL;
        need_d = DAY_MASK | MON_MASK;
      end
      default:  legal = 1'b0;
    endcase
    // Whole-second periods only fire as a new second begins
    hit = half_tick && legal && !(whole_sec && half_phase)
          && (((alarm_time ^ now_time) & need_t) == ZERO_WORD)
          && (((alarm_date ^ now_date) & need_d) == ZERO_WORD);
  end

endmodule : rtcal_match

// ===== rtl/rtcal_alarm.sv
// Alarm time/date registers, match engine and AXI4-Lite slave
`timescale 1ns/1ps
module rtcal_alarm
  import rtcal_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // AXI4-Lite write
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Running clock and calendar
  input  wire logic        half_tick,
  input  wire logic        half_phase,
  input  wire logic [31:0] now_time,
  input  wire logic [31:0] now_date,
  // Alarm outputs
  output logic             alarm_event,
  output logic             alarm_pulse,
  output logic             alarm_armed,
  output logic             irq
);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Bus state
  logic        awready_reg, awready_next;
  logic        wready_reg, wready_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        aw_held_reg, aw_held_next;
  logic        w_held_reg, w_held_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;

  // Alarm state
  logic [31:0]      time_reg, time_next;
  logic [31:0]      date_reg, date_next;
  logic             arm_reg, arm_next;
  logic             wrap_reg, wrap_next;
  logic             piv_reg, piv_next;
  logic [3:0]       mm_reg, mm_next;
  logic [7:0]       cnt_reg, cnt_next;
  logic             pulse_reg, pulse_next;
  logic [IRQ_W-1:0] stat_reg, stat_next;
  logic [IRQ_W-1:0] imsk_reg, imsk_next;
  logic             irq_reg, irq_next;
  logic             event_reg, event_next;

  logic        wr_go;
  logic        hit;
  logic        fire;
  logic [31:0] ctrl_word;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic        wr_ok;
  logic [31:0] cval;
  logic [31:0] wval;

  rtcal_match u_match (
    .half_tick  (half_tick),
    .half_phase (half_phase),
    .now_time   (now_time),
    .now_date   (now_date),
    .match_mask (mm_reg),
    .alarm_time (time_reg),
    .alarm_date (date_reg),
    .hit        (hit)
  );

  assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  assign fire  = arm_reg && hit;

  // Armed: the initial-level bit reads back the live pulse
  always_comb begin
    ctrl_word = ZERO_WORD;
    ctrl_word[CTRL_ARM_BIT]  = arm_reg;
    ctrl_word[CTRL_WRAP_BIT] = wrap_reg;
    ctrl_word[CTRL_PIV_BIT]  = arm_reg ? pulse_reg : piv_reg;
    ctrl_word[CTRL_MM_LSB +: CTRL_MM_W]   = mm_reg;
    ctrl_word[CTRL_CNT_LSB +: CTRL_CNT_W] = cnt_reg;
  end

  always_comb begin
    rd_word = ZERO_WORD;
    rd_ok   = 1'b1;
    case (araddr)
      ADDR_TIME: rd_word = time_reg & TIME_IMPL;
      ADDR_DATE: rd_word = date_reg & DATE_IMPL;
      ADDR_CTRL: rd_word = ctrl_word;
      ADDR_STAT: rd_word = {{(32-IRQ_W){1'b0}}, stat_reg};
      ADDR_IMSK: rd_word = {{(32-IRQ_W){1'b0}}, imsk_reg};
      default:   rd_ok   = 1'b0;
    endcase
  end

  assign wr_ok = (waddr_reg == ADDR_TIME) || (waddr_reg == ADDR_DATE) ||
                 (waddr_reg == ADDR_CTRL) || (waddr_reg == ADDR_STAT) ||
                 (waddr_reg == ADDR_IMSK);

  // Bus channels; address and data are taken in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      waddr_next   = awaddr;
    end
    if (wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next  = wdata;
      wstrb_next  = wstrb;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_go) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_word;
      rresp_next  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= ZERO_WORD;
      rresp_reg   <= RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      waddr_reg   <= ADDR_TIME;
      wdata_reg   <= ZERO_WORD;
      wstrb_reg   <= 4'h0;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
    end
  end

  // Alarm registers; a same-cycle event overrides a software write
  always_comb begin
    time_next  = time_reg;
    date_next  = date_reg;
    arm_next   = arm_reg;
    wrap_next  = wrap_reg;
    piv_next   = piv_reg;
    mm_next    = mm_reg;
    cnt_next   = cnt_reg;
    pulse_next = pulse_reg;
    stat_next  = stat_reg;
    imsk_next  = imsk_reg;
    event_next = 1'b0;
    cval       = merge(ctrl_word, wdata_reg, wstrb_reg);
    wval       = merge(ZERO_WORD, wdata_reg, wstrb_reg);
    if (wr_go) begin
      case (waddr_reg)
        ADDR_TIME: time_next = merge(time_reg, wdata_reg, wstrb_reg)
                               & TIME_IMPL;
        ADDR_DATE: date_next = merge(date_reg, wdata_reg, wstrb_reg)
                               & DATE_IMPL;
        ADDR_CTRL: begin
          arm_next  = cval[CTRL_ARM_BIT];
          wrap_next = cval[CTRL_WRAP_BIT];
          mm_next   = cval[CTRL_MM_LSB +: CTRL_MM_W];
          cnt_next  = cval[CTRL_CNT_LSB +: CTRL_CNT_W];
          if (!arm_reg) begin
            piv_next = cval[CTRL_PIV_BIT];
          end
        end
        ADDR_STAT: stat_next = stat_reg & ~wval[IRQ_W-1:0];
        ADDR_IMSK: imsk_next = wval[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (fire) begin
      event_next = 1'b1;
      pulse_next = !pulse_reg;
      stat_next[IRQ_EVENT] = 1'b1;
      if (cnt_reg != COUNT_ZERO) begin
        cnt_next = cnt_reg - COUNT_ONE;
      end else if (wrap_reg) begin
        cnt_next = COUNT_MAX;
      end else begin
        cnt_next = COUNT_ZERO;
        arm_next = 1'b0;
        stat_next[IRQ_DONE] = 1'b1;
      end
    end
    // Disarmed, or disarming in this cycle: the pulse starts from the new level
    if (!arm_reg || !arm_next) begin
      pulse_next = piv_next;
    end
    irq_next = |(stat_next & imsk_next);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      time_reg  <= TIME_RESET;
      date_reg  <= DATE_RESET;
      arm_reg   <= 1'b0;
      wrap_reg  <= 1'b0;
      piv_reg   <= 1'b0;
      mm_reg    <= MM_HALF;
      cnt_reg   <= COUNT_ZERO;
      pulse_reg <= 1'b0;
      stat_reg  <= IRQ_NONE;
      imsk_reg  <= IRQ_NONE;
      irq_reg   <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      time_reg  <= time_next;
      date_reg  <= date_next;
      arm_reg   <= arm_next;
      wrap_reg  <= wrap_next;
      piv_reg   <= piv_next;
      mm_reg    <= mm_next;
      cnt_reg   <= cnt_next;
      pulse_reg <= pulse_next;
      stat_reg  <= stat_next;
      imsk_reg  <= imsk_next;
      irq_reg   <= irq_next;
      event_reg <= event_next;
    end
  end

  assign awready     = awready_reg;
  assign wready      = wready_reg;
  assign bvalid      = bvalid_reg;
  assign bresp       = bresp_reg;
  assign arready     = arready_reg;
  assign rvalid      = rvalid_reg;
  assign rdata       = rdata_reg;
  assign rresp       = rresp_reg;
  assign alarm_event = event_reg;
  assign alarm_pulse = pulse_reg;
  assign alarm_armed = arm_reg;
  assign irq         = irq_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_hour_store;
    wr_go && waddr_reg == ADDR_TIME && wstrb_reg[3] |=>
      (time_reg & HOUR_MASK) == ($past(wdata_reg) & HOUR_MASK);
  endproperty
  a_hour_store: assert property (p_hour_store)
    else $error("hour field not stored");

  property p_min_store;
    wr_go && waddr_reg == ADDR_TIME && wstrb_reg[2] |=>
      (time_reg & (MIN_T_MASK | MIN_O_MASK)) ==
      ($past(wdata_reg) & (MIN_T_MASK | MIN_O_MASK));
  endproperty
  a_min_store: assert property (p_min_store)
    else $error("minute field not stored");

  property p_sec_store;
    wr_go && waddr_reg == ADDR_TIME && wstrb_reg[1] |=>
      (time_reg & (SEC_T_MASK | SEC_O_MASK)) ==
      ($past(wdata_reg) & (SEC_T_MASK | SEC_O_MASK));
  endproperty
  a_sec_store: assert property (p_sec_store)
    else $error("second field not stored");

  property p_time_rsv;
    arvalid && arready_reg && araddr == ADDR_TIME |=>
      rvalid_reg && (rdata_reg & ~TIME_IMPL) == ZERO_WORD;
  endproperty
  a_time_rsv: assert property (p_time_rsv)
    else $error("unused time bits read non-zero");

  property p_date_store;
    wr_go && waddr_reg == ADDR_DATE && wstrb_reg == 4'hf |=>
      date_reg == ($past(wdata_reg) & DATE_IMPL);
  endproperty
  a_date_store: assert property (p_date_store)
    else $error("date fields not stored");

  property p_date_rsv;
    arvalid && arready_reg && araddr == ADDR_DATE |=>
      (rdata_reg & ~DATE_IMPL) == ZERO_WORD;
  endproperty
  a_date_rsv: assert property (p_date_rsv)
    else $error("unused date bits read non-zero");

  property p_reserved_mode;
    mm_reg > MM_YEAR |-> !hit;
  endproperty
  a_reserved_mode: assert property (p_reserved_mode)
    else $error("reserved mask code raised a match");

  property p_half_fire;
    arm_reg && mm_reg == MM_HALF && half_tick |=> alarm_event;
  endproperty
  a_half_fire: assert property (p_half_fire)
    else $error("half-second alarm missed");

  property p_count_dec;
    fire && cnt_reg != COUNT_ZERO |=> cnt_reg == $past(cnt_reg) - COUNT_ONE;
  endproperty
  a_count_dec: assert property (p_count_dec)
    else $error("repeat count did not decrement");

  property p_count_wrap;
    fire && cnt_reg == COUNT_ZERO && wrap_reg |=>
      cnt_reg == COUNT_MAX && arm_reg;
  endproperty
  a_count_wrap: assert property (p_count_wrap)
    else $error("repeat count did not wrap");

  property p_disarm;
    fire && cnt_reg == COUNT_ZERO && !wrap_reg |=>
      !arm_reg && stat_reg[IRQ_DONE];
  endproperty
  a_disarm: assert property (p_disarm)
    else $error("arm not cleared at end of repeats");

  property p_piv_locked;
    arm_reg && wr_go && waddr_reg == ADDR_CTRL |=> piv_reg == $past(piv_reg);
  endproperty
  a_piv_locked: assert property (p_piv_locked)
    else $error("initial level changed while armed");

  property p_pulse_toggle;
    fire && (cnt_reg != COUNT_ZERO || wrap_reg) |=>
      alarm_pulse != $past(pulse_reg);
  endproperty
  a_pulse_toggle: assert property (p_pulse_toggle)
    else $error("pulse did not toggle on event");

  c_wrap:   cover property (fire && cnt_reg == COUNT_ZERO && wrap_reg);
  c_disarm: cover property (fire && cnt_reg == COUNT_ZERO && !wrap_reg);
  c_year:   cover property (fire && mm_reg == MM_YEAR);
  c_irq:    cover property (irq_reg ##1 !irq_reg);

endmodule : rtcal_alarm

// ===== verif/rtcal_alarm_test.sv
// Self-checking bench of the alarm time/date match block
`timescale 1ns/1ps
module rtcal_alarm_test
  import rtcal_pkg::*;
;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        half_tick, half_phase;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, now_time, now_date, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        alarm_event, alarm_pulse, alarm_armed, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] d, m_time, m_now;
  int          n_mismatch, check_count, seed, i;
  int          m_arm, m_wrap, m_piv, m_pulse, m_mm, m_cnt, m_stat, m_imsk;
  int          m_dblk;

  rtcal_alarm rtcal_alarm_inst (
    .clk(clk), .nrst(nrst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .half_tick(half_tick), .half_phase(half_phase),
    .now_time(now_time), .now_date(now_date),
    .alarm_event(alarm_event), .alarm_pulse(alarm_pulse),
    .alarm_armed(alarm_armed), .irq(irq)
  );

  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Ready lines stay high, so a response is taken at the edge it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
    end
  endtask : rd

  function automatic logic [31:0] ctrl_exp();
    return {16'h0, m_arm[0], m_wrap[0], m_pulse[0], 1'b0, m_mm[3:0],
            m_cnt[7:0]};
  endfunction : ctrl_exp

  task automatic set_ctrl(input int arm, wrap, pulse_initial_level, mm, cnt);
    if (m_arm == 0) begin
      m_piv = pulse_initial_level;
      m_pulse = pulse_initial_level;
    end
    m_arm = arm;
    m_wrap = wrap;
    m_mm = mm;
    m_cnt = cnt;
    wr(ADDR_CTRL, {16'h0, arm[0], wrap[0], pulse_initial_level[0], 1'b0, mm[3:0],
       cnt[7:0]}, RESP_OKAY);
    chk("alarm_pulse", m_pulse, alarm_pulse);
  endtask : set_ctrl

  task automatic set_reg(input logic [7:0] a, input int v, clr);
    wr(a, v, RESP_OKAY);
    if (clr) m_stat = m_stat & ~v;
    else m_imsk = v;
    // Let the registered interrupt line follow the new status
    @(posedge clk);
    chk("irq", (m_stat & m_imsk) != 0, irq);
  endtask : set_reg

  task automatic tick(input int ph);
    int fire;
    fire = m_arm && (m_mm == 0 || (m_mm <= 9 && ph == 0 &&
           (m_mm == 1 || (m_now == m_time && !m_dblk[m_mm]))));
    half_phase <= ph[0];
    half_tick <= 1'b1;
    @(posedge clk);
    half_tick <= 1'b0;
    @(posedge clk);
    if (fire) begin
      m_stat = m_stat | 1;
      if (m_cnt == 0 && m_wrap == 0) begin
        m_arm = 0;
        m_pulse = m_piv;
        m_stat = m_stat | 2;
      end else begin
        m_pulse = 1 - m_pulse;
        m_cnt = (m_cnt + 255) % 256;
      end
    end
    chk("alarm_event", fire, alarm_event);
    chk("alarm_armed", m_arm, alarm_armed);
    chk("alarm_pulse", m_pulse, alarm_pulse);
    chk("irq", (m_stat & m_imsk) != 0, irq);
    rd(ADDR_CTRL, ctrl_exp(), RESP_OKAY);
  endtask : tick

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Whole run needs a few hundred cycles; this is far beyond it
  initial begin
    #2000000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    {nrst, awvalid, wvalid, arvalid, half_tick, half_phase} = 6'h00;
    {bready, rready} = 2'h3;
    {awaddr, araddr} = 16'h0000;
    {wdata, now_time, now_date} = 96'h0;
    wstrb = 4'hf;
    {n_mismatch, check_count, m_stat, m_imsk} = '0;
    {m_arm, m_wrap, m_piv, m_pulse, m_mm, m_cnt} = '0;
    m_dblk = 0;
    seed = 52891;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 5; i++) begin
      rd(8'(4 * i), 32'h0, RESP_OKAY);
    end
    for (i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'hffffffff : $random(seed);
      wr(ADDR_TIME, d, RESP_OKAY);
      rd(ADDR_TIME, d & 32'h3f7f7f00, RESP_OKAY);
      wr(ADDR_DATE, ~d, RESP_OKAY);
      rd(ADDR_DATE, ~d & 32'h001f3f07, RESP_OKAY);
    end
    // Only the minute lane is written; the other lanes keep their value
    wstrb <= 4'h4;
    wr(ADDR_TIME, 32'h00000000, RESP_OKAY);
    wstrb <= 4'hf;
    rd(ADDR_TIME, d & 32'h3f007f00, RESP_OKAY);
    wr(8'h14, d, RESP_SLVERR);
    rd(8'h14, 32'h0, RESP_SLVERR);
    m_time = 32'h12345600;
    m_now = m_time;
    wr(ADDR_TIME, m_time, RESP_OKAY);
    wr(ADDR_DATE, 32'h00120305, RESP_OKAY);
    now_time <= m_time;
    now_date <= 32'h00120305;
    set_reg(ADDR_IMSK, 1, 0);
    set_ctrl(0, 0, 1, 0, 0);
    // Every code with all fields matching, in both halves of a second
    for (i = 0; i < 16; i++) begin
      set_ctrl(1, 1, 1, i, 5);
      tick(0);
      tick(1);
    end
    rd(ADDR_STAT, m_stat, RESP_OKAY);
    set_reg(ADDR_STAT, 3, 1);
    m_now = m_time ^ 32'h00000100;
    now_time <= m_now;
    for (i = 1; i < 4; i++) begin
      set_ctrl(1, 1, 1, i, 5);
      tick(0);
    end
    m_now = m_time;
    now_time <= m_now;
    // Each date field differs in turn; only codes comparing it stay quiet
    for (i = 0; i < 12; i++) begin
      now_date <= (i < 4) ? 32'h00120306 :
                  (i < 8) ? 32'h00120405 : 32'h00020305;
      m_dblk = (i < 4) ? 32'h080 : (i < 8) ? 32'h300 : 32'h200;
      set_ctrl(1, 1, 1, 6 + i % 4, 5);
      tick(0);
    end
    now_date <= 32'h00120305;
    m_dblk = 0;
    set_reg(ADDR_IMSK, 3, 0);
    set_ctrl(1, 0, 1, 0, 2);
    repeat (4) tick(0);
    rd(ADDR_STAT, m_stat, RESP_OKAY);
    set_ctrl(1, 1, 0, 0, 0);
    tick(0);
    set_ctrl(1, 1, 0, 0, 3);
    rd(ADDR_CTRL, ctrl_exp(), RESP_OKAY);
    set_reg(ADDR_STAT, 3, 1);
    set_reg(ADDR_IMSK, 0, 0);
    tick(0);
    rd(ADDR_STAT, m_stat, RESP_OKAY);
    end_sim();
  end
endmodule : rtcal_alarm_test
